// file: verilog/sadc_pkg.sv
// Shared constants, types and helpers of the serial converter control block.
// Assumes one system clock domain plus a host-driven shift clock domain.
package sadc_pkg;

	// ****************************************
	// Sizes and counts
	// ****************************************
	localparam int RES_BITS = 10;
	localparam int CHAN_BITS = 4;
	localparam int N_EXT_CHAN = 11;
	localparam logic [3:0] SELF_TEST_CHAN = 4'hb;
	localparam int CONV_CYCLES = 44;
	localparam int SAMPLE_CYCLES = 24;
	localparam int FILTER_CYCLES = 3;
	localparam int LAUNCH_EDGE = 10;
	localparam int CNT_BITS = 5;
	localparam int CCNT_BITS = 6;
	localparam int HIST_BITS = 10;
	localparam int SYNC_STAGES = 3;

	// ****************************************
	// Field positions in the shifted-in address history at launch
	// ****************************************
	localparam int HIST_MODE_POS = 9;
	localparam int HIST_CHAN_MSB = 8;
	localparam int HIST_CHAN_LSB = 5;

	// ****************************************
	// Values after reset, and the first trial code
	// ****************************************
	localparam logic [9:0] RESULT_RST = 10'h000;
	localparam logic [9:0] TRIAL_FIRST = 10'h200;
	localparam logic [4:0] CNT_RST = 5'h00;
	localparam logic [5:0] CCNT_RST = 6'h00;
	localparam logic [1:0] FILT_RST = 2'h0;
	localparam logic [9:0] HIST_RST = 10'h000;
	localparam logic CS_IDLE = 1'b1;

	// Analog front end controls travel together
	typedef struct packed {
		logic sample;
		logic [3:0] mux_sel;
		logic [9:0] dac_code;
	} sadc_afe_t;

	typedef enum logic [2:0] {
		F_IDLE = 3'b001,
		F_FILTER = 3'b010,
		F_ACTIVE = 3'b100
	} sadc_frame_t;

	typedef enum logic [2:0] {
		C_IDLE = 3'b001,
		C_SAMPLE = 3'b010,
		C_TRIAL = 3'b100
	} sadc_conv_t;

	// Gray code back to binary
	function automatic logic [4:0] gray2bin(input logic [4:0] g);
		logic [4:0] b;
		b[4] = g[4];
		for (int i = 3; i >= 0; i--) begin
			b[i] = b[i + 1] ^ g[i];
		end
		return b;
	endfunction : gray2bin

	// Channel field of the history; codes past the self-test one fold onto it
	function automatic logic [3:0] chan_of(input logic [9:0] hist);
		logic [3:0] c;
		c = hist[HIST_CHAN_MSB:HIST_CHAN_LSB];
		return (c > SELF_TEST_CHAN) ? SELF_TEST_CHAN : c;
	endfunction : chan_of

	// Result bit due on the serial output after idx falling shift edges
	function automatic logic bit_of(input logic [9:0] r, input logic [4:0] idx);
		logic b;
		b = 1'b0;
		if (idx < 5'(RES_BITS)) begin
			b = r[4'(RES_BITS - 1) - idx[3:0]];
		end
		return b;
	endfunction : bit_of

endpackage : sadc_pkg

// file: verilog/sadc_sync_pin.sv
// Three-stage synchroniser for levels and quasi-static words from another clock.
// Assumes the source word is stable, or gray coded, while it is sampled.
`timescale 1ns/1ns
`default_nettype none
module sadc_sync_pin #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output var logic [W-1:0] q
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_q;

	// A change is only taken once the two late stages agree
	always_comb begin
		next_q = (s2 == s3) ? s3 : q;
	end

	// Stage one feeds stage two only
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s1 <= RST;
			s2 <= RST;
			s3 <= RST;
			q <= RST;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q <= next_q;
		end
	end

endmodule : sadc_sync_pin
`default_nettype wire

// file: verilog/sadc_ctrl.sv
// Control and serial interface of a 10-bit successive-approximation converter.
// Assumes the host drives cs_n, io_clk and addr_in, and an analog front end
// takes the afe controls and answers with cmp_above on the system clock.
//
// How it works
// - Conversion lasts 44 system clock periods
// - Tenth falling shift edge launches conversion
// - Converts channel held in address at launch
// - MSB driven on data out once selected
// - Bits 8..0 leave on first nine falls
// - Shift falls ignored three cycles after select
// - Twelve selections: eleven inputs plus self-test
// - Sampling automatic or timed by the host
// - Result out while next address shifts in
// - Three-state data out, three control inputs
// - Ten-bit result held in output register
`timescale 1ns/1ns
`default_nettype none
module sadc_ctrl (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic io_clk,
	input wire logic cs_n,
	input wire logic addr_in,
	input wire logic cmp_above,
	output var logic data_out,
	output var logic data_oe,
	output var logic conv_busy,
	output var sadc_pkg::sadc_afe_t afe
);

	// ****************************************
	// Shift clock domain
	// ****************************************
	logic [1:0] io_rst_sync;
	logic io_rst_n;
	logic [4:0] edge_bin;
	logic [4:0] edge_gray;
	logic [4:0] next_edge_bin;
	logic [4:0] next_edge_gray;
	logic [9:0] hist;
	logic [9:0] next_hist;

	assign io_rst_n = io_rst_sync[1];

	// Reset reaches this domain only while the host runs the shift clock
	always_ff @(posedge io_clk) begin
		io_rst_sync <= {io_rst_sync[0], rst_n};
	end

	// Falling edges counted in gray so the count crosses safely
	always_comb begin
		next_edge_bin = io_rst_n ? edge_bin + 5'h01 : sadc_pkg::CNT_RST;
		next_edge_gray = next_edge_bin ^ (next_edge_bin >> 1);
	end

	always_ff @(negedge io_clk) begin
		edge_bin <= next_edge_bin;
		edge_gray <= next_edge_gray;
	end

	// Address bits shift in on every rising edge, oldest at the top
	always_comb begin
		next_hist = io_rst_n ? {hist[8:0], addr_in} : sadc_pkg::HIST_RST;
	end

	always_ff @(posedge io_clk) begin
		hist <= next_hist;
	end

	// ****************************************
	// Crossings into the system clock domain
	// ****************************************
	logic cs_s;
	logic [4:0] gray_s;
	logic [9:0] hist_s;
	logic [4:0] edge_cnt;

	sadc_sync_pin #(.W(1), .RST(sadc_pkg::CS_IDLE)) u_cs_sync (
		.clock(clock),
		.rst_n(rst_n),
		.d(cs_n),
		.q(cs_s)
	);

	sadc_sync_pin #(.W(5), .RST(sadc_pkg::CNT_RST)) u_cnt_sync (
		.clock(clock),
		.rst_n(rst_n),
		.d(edge_gray),
		.q(gray_s)
	);

	// The history is quasi-static: the host stops the shift clock at launch
	sadc_sync_pin #(.W(10), .RST(sadc_pkg::HIST_RST)) u_hist_sync (
		.clock(clock),
		.rst_n(rst_n),
		.d(hist),
		.q(hist_s)
	);

	assign edge_cnt = sadc_pkg::gray2bin(gray_s);

	// ****************************************
	// Frame control and serial output
	// ****************************************
	sadc_pkg::sadc_frame_t frame;
	sadc_pkg::sadc_frame_t next_frame;
	logic [1:0] filt;
	logic [1:0] next_filt;
	logic [4:0] base;
	logic [4:0] next_base;
	logic [4:0] idx;
	logic launched;
	logic next_launched;
	logic launch;
	logic next_data_out;
	logic next_data_oe;
	logic [9:0] result;

	assign idx = edge_cnt - base;

	// Edges during the filter are swallowed; the count restarts after it
	always_comb begin
		next_frame = frame;
		next_filt = filt;
		next_base = base;
		next_launched = launched;
		launch = 1'b0;
		next_data_oe = !cs_s;
		next_data_out = result[sadc_pkg::RES_BITS - 1];
		unique case (frame)
			sadc_pkg::F_IDLE: begin
				next_launched = 1'b0;
				next_filt = sadc_pkg::FILT_RST;
				if (!cs_s) begin
					next_frame = sadc_pkg::F_FILTER;
				end
			end
			sadc_pkg::F_FILTER: begin
				next_filt = filt + 2'h1;
				if (cs_s) begin
					next_frame = sadc_pkg::F_IDLE;
				end else if (filt == 2'(sadc_pkg::FILTER_CYCLES - 1)) begin
					next_frame = sadc_pkg::F_ACTIVE;
					next_base = edge_cnt;
				end
			end
			sadc_pkg::F_ACTIVE: begin
				next_data_out = sadc_pkg::bit_of(result, idx);
				if (cs_s) begin
					next_frame = sadc_pkg::F_IDLE;
				end else if (idx == 5'(sadc_pkg::LAUNCH_EDGE) && !launched) begin
					next_launched = 1'b1;
					launch = !conv_busy;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			frame <= sadc_pkg::F_IDLE;
			filt <= sadc_pkg::FILT_RST;
			base <= sadc_pkg::CNT_RST;
			launched <= 1'b0;
			data_out <= 1'b0;
			data_oe <= 1'b0;
		end else begin
			frame <= next_frame;
			filt <= next_filt;
			base <= next_base;
			launched <= next_launched;
			data_out <= next_data_out;
			data_oe <= next_data_oe;
		end
	end

	// ****************************************
	// Conversion sequencer
	// ****************************************
	sadc_pkg::sadc_conv_t conv;
	sadc_pkg::sadc_conv_t next_conv;
	logic [5:0] ccnt;
	logic [5:0] next_ccnt;
	logic [9:0] trial;
	logic [9:0] next_trial;
	logic [9:0] next_result;
	logic sh_host;
	logic next_sh_host;
	logic next_busy;
	logic [5:0] step;
	logic [3:0] bitpos;
	sadc_pkg::sadc_afe_t next_afe;

	assign step = ccnt - 6'(sadc_pkg::SAMPLE_CYCLES);
	assign bitpos = 4'(sadc_pkg::RES_BITS - 1) - step[4:1];

	// Sample phase then two cycles per bit: set the trial bit, then judge it
	always_comb begin
		next_conv = conv;
		next_ccnt = ccnt + 6'h01;
		next_trial = trial;
		next_result = result;
		next_sh_host = sh_host;
		next_afe = afe;
		unique case (conv)
			sadc_pkg::C_IDLE: begin
				next_ccnt = sadc_pkg::CCNT_RST;
				next_afe.sample = sh_host;
				if (launch) begin
					next_conv = sadc_pkg::C_SAMPLE;
					next_trial = sadc_pkg::RESULT_RST;
					next_afe.mux_sel = sadc_pkg::chan_of(hist_s);
					next_afe.sample = !sh_host;
					next_sh_host = hist_s[sadc_pkg::HIST_MODE_POS];
				end
			end
			sadc_pkg::C_SAMPLE: begin
				if (ccnt == 6'(sadc_pkg::SAMPLE_CYCLES - 1)) begin
					next_conv = sadc_pkg::C_TRIAL;
					next_afe.sample = 1'b0;
					next_trial = sadc_pkg::TRIAL_FIRST;
				end
			end
			sadc_pkg::C_TRIAL: begin
				if (step[0]) begin
					next_trial[bitpos] = cmp_above;
					if (bitpos != 4'h0) begin
						next_trial[bitpos - 4'h1] = 1'b1;
					end
				end
				if (ccnt == 6'(sadc_pkg::CONV_CYCLES - 1)) begin
					next_conv = sadc_pkg::C_IDLE;
					next_result = next_trial;
				end
			end
		endcase
		next_afe.dac_code = next_trial;
		next_busy = (next_conv != sadc_pkg::C_IDLE);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			conv <= sadc_pkg::C_IDLE;
			ccnt <= sadc_pkg::CCNT_RST;
			trial <= sadc_pkg::RESULT_RST;
			result <= sadc_pkg::RESULT_RST;
			sh_host <= 1'b0;
			conv_busy <= 1'b0;
			afe <= '0;
		end else begin
			conv <= next_conv;
			ccnt <= next_ccnt;
			trial <= next_trial;
			result <= next_result;
			sh_host <= next_sh_host;
			conv_busy <= next_busy;
			afe <= next_afe;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_conv_run;
		conv_busy throughout (##43 1'b1);
	endsequence

	sequence s_auto_sample;
		afe.sample throughout (##23 1'b1);
	endsequence

	conv_length_a: assert property (launch |=> s_conv_run ##1 !conv_busy)
		else $error("conversion not 44 cycles long");

	launch_edge_a: assert property ($rose(conv_busy) |->
		$past(frame == sadc_pkg::F_ACTIVE && idx == 5'(sadc_pkg::LAUNCH_EDGE) && !launched))
		else $error("launch away from tenth falling edge");

	launch_chan_a: assert property (launch |=>
		afe.mux_sel == $past(sadc_pkg::chan_of(hist_s)))
		else $error("wrong channel at launch");

	msb_first_a: assert property ((frame == sadc_pkg::F_IDLE && !cs_s) |=>
		data_oe && data_out == $past(result[sadc_pkg::RES_BITS - 1]))
		else $error("msb not driven at select");

	shift_bit_a: assert property ((frame == sadc_pkg::F_ACTIVE && !cs_s
		&& idx < 5'(sadc_pkg::RES_BITS))
		|=> data_out == $past(result[4'(sadc_pkg::RES_BITS - 1) - idx[3:0]]))
		else $error("serial bit out of order");

	cs_filter_a: assert property (((frame == sadc_pkg::F_IDLE && !cs_s) ##1 (!cs_s)[*3])
		|-> frame == sadc_pkg::F_FILTER && $past(frame, 2) == sadc_pkg::F_FILTER
		##1 frame == sadc_pkg::F_ACTIVE)
		else $error("select filter length wrong");

	mux_range_a: assert property (afe.mux_sel <= sadc_pkg::SELF_TEST_CHAN)
		else $error("channel select out of range");

	auto_sample_a: assert property ((launch && !sh_host) |=> s_auto_sample
		##1 !afe.sample)
		else $error("automatic sample window wrong");

	result_load_a: assert property ((conv == sadc_pkg::C_TRIAL
		&& ccnt == 6'(sadc_pkg::CONV_CYCLES - 1)) |=>
		result[9:1] == $past(afe.dac_code[9:1]) && result[0] == $past(cmp_above))
		else $error("result not loaded from trial");

	data_hiz_a: assert property (cs_s |=> !data_oe)
		else $error("data out driven while deselected");

endmodule : sadc_ctrl
`default_nettype wire

// file: testbench/sadc_host.sv
// Host model: drives chip select, shift clock and serial address bit.
// Assumes the converter takes these through its own synchronisers.
`timescale 1ns/1ns
`default_nettype none
module sadc_host (
	output var logic cs_n,
	output var logic io_clk,
	output var logic addr_in,
	input wire logic data_out
);
	logic link_clk;

	// ****************
	// Link timing
	// ****************
	// 6 ns base; shift half period of 120 ticks keeps above the sync latency
	initial begin
		link_clk = 1'b0;
		cs_n = 1'b1;
		io_clk = 1'b0;
		addr_in = 1'b0;
		forever #3 link_clk = ~link_clk;
	end

	// Wait whole link ticks
	task automatic ticks(input int n);
		repeat (n) @(posedge link_clk);
	endtask : ticks

	// Free shift clock pulses with select high; the link side only resets while it runs
	task automatic pulse(input int n);
		repeat (n) begin
			ticks(20);
			io_clk = 1'b1;
			ticks(20);
			io_clk = 1'b0;
		end
	endtask : pulse

	// One frame: word goes in MSB first while the result comes out
	task automatic frame(input logic [4:0] word, input int falls, input bit early,
		output logic [9:0] got);
		got = 10'h000;
		if (early) begin
			io_clk = 1'b1; // Stray fall lands inside the select filter
			ticks(120);
		end
		cs_n = 1'b0;
		ticks(50);
		io_clk = 1'b0;
		ticks(150); // Select setup before the first edge
		for (int k = 0; k < falls; k++) begin
			addr_in = (k < 5) ? word[4 - k] : k[0];
			ticks(120);
			got[9 - k] = data_out;
			io_clk = 1'b1;
			ticks(120);
			io_clk = 1'b0;
		end
		ticks(200);
		cs_n = 1'b1;
		addr_in = ~addr_in; // Released line must not keep its last value
		ticks(800); // Shift clock held low through the conversion
	endtask : frame
endmodule : sadc_host
`default_nettype wire

// file: testbench/serial_adc_control_interface_tb_top.sv
// Bench of the serial converter control block, host model and analog stub.
// Assumes sadc_pkg, the design files and the host model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module serial_adc_control_interface_tb_top;
	`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
	logic clock;
	logic rst_n;
	wire logic data_out, data_oe, conv_busy, cs_n, io_clk, addr_in, sdo, cmp_above;
	wire sadc_pkg::sadc_afe_t afe;
	int failures = 0;
	int samples_checked = 0;
	int bcnt = 0;
	int launches = 0;
	int hicnt = 0;
	int l_len;
	int n0;
	logic [3:0] l_mux;
	logic l_smp;
	logic l_smp24;
	logic prev_mode;
	logic [3:0] ch;
	logic [9:0] exp_r;
	logic [9:0] got;
	logic [9:0] vin [12] = '{10'h001, 10'h3ff, 10'h2aa, 10'h155, 10'h080, 10'h1c7,
		10'h300, 10'h0f0, 10'h222, 10'h3a5, 10'h012, 10'h200};
	// Rows: address word (mode, channel) beside the channel that it must select
	logic [8:0] rows [6] = '{9'h000, 9'h111, 9'h055, 9'h1aa, 9'h0bb, 9'h1fb};

	sadc_ctrl DUT (.clock(clock), .rst_n(rst_n), .io_clk(io_clk), .cs_n(cs_n),
		.addr_in(addr_in), .cmp_above(cmp_above), .data_out(data_out), .data_oe(data_oe),
		.conv_busy(conv_busy), .afe(afe));
	sadc_host host (.cs_n(cs_n), .io_clk(io_clk), .addr_in(addr_in), .data_out(sdo));

	// Three-state pin as the host sees it; ideal comparator on the chosen input
	assign sdo = data_oe ? data_out : 1'bz;
	assign cmp_above = vin[afe.mux_sel] >= afe.dac_code;

	// ****************
	// Clock and monitors
	// ****************
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Conversion record: launch count, channel, sampling and length
	always @(posedge clock) begin
		if (conv_busy === 1'b1) begin
			if (bcnt == 0) begin
				l_mux = afe.mux_sel;
				l_smp = afe.sample;
				launches++;
			end
			if (bcnt == 24) l_smp24 = afe.sample;
			bcnt++;
		end else if (bcnt != 0) begin
			l_len = bcnt;
			bcnt = 0;
		end
		hicnt = (cs_n === 1'b1) ? hicnt + 1 : 0;
		if (hicnt > 8) `CHK(data_oe, 1'b0)
	end

	// Verdict and end of run
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	// Hang guard, far beyond nine frames
	initial begin
		#1000000;
		failures++;
		stop_test();
	end

	// ****************
	// Sequence
	// ****************
	initial begin
		rst_n = 1'b0;
		// Shift clock pulses in reset, else the link-side counters stay unknown
		fork
			host.pulse(3);
			repeat (8) @(negedge clock);
		join
		`CHK({data_oe, data_out, conv_busy, afe}, 18'h00000)
		rst_n = 1'b1;
		host.pulse(3);
		exp_r = 10'h000;
		prev_mode = 1'b0;
		for (int i = 0; i < 6; i++) begin
			n0 = launches;
			ch = rows[i][3:0];
			host.frame(rows[i][8:4], 10, 1'b0, got);
			`CHK(got, exp_r)
			`CHK(launches - n0, 1)
			`CHK(l_mux, ch)
			`CHK(l_len, 44)
			`CHK(l_smp, ~prev_mode)
			`CHK(l_smp24, 1'b0)
			prev_mode = rows[i][8];
			exp_r = vin[ch];
		end
		// Aborted frame: too few falls, no launch, result kept
		n0 = launches;
		host.frame(5'h03, 5, 1'b0, got);
		`CHK(launches - n0, 0)
		`CHK(got[9:5], exp_r[9:5])
		// Stray fall in the filter must not count towards the tenth
		host.frame(5'h02, 10, 1'b1, got);
		`CHK(got, exp_r)
		`CHK(launches - n0, 1)
		host.frame(5'h00, 10, 1'b0, got);
		`CHK(got, vin[2])
		stop_test();
	end
endmodule : serial_adc_control_interface_tb_top
`default_nettype wire
